// ===== bench/bsio_mem_model.sv
`default_nettype none
module bsio_mem_model (
  // clock and attach
  input  wire logic        mclk,
  input  wire logic        attached,
  // strobes and lines as seen at the pins
  input  wire logic        ale,
  input  wire logic        oe_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] ad,
  output logic      [15:0] drv
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem_q [256];
  logic [7:0]  addr_q = 8'h00;
  logic [15:0] last_q = 16'h0000;

  always @(posedge mclk) begin
    if (attached && ale)
      addr_q <= ad[7:0];
    if (attached && !wr_n)
      mem_q[addr_q] <= ad;
    if (!oe_n)
      last_q <= mem_q[addr_q];
  end

  // released lines show the inverse of the last value driven
  assign drv = !oe_n ? mem_q[addr_q] : ~last_q;
endmodule
`default_nettype wire

// ===== bench/bus_shared_io_ports_tb.sv
`default_nettype none
module bus_shared_io_ports_tb;
  import bsio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk     = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  cfg_mode = 2'h2;
  bsio_xreq_t  xbus_req = '0;
  logic        attached = 1'b0;
  logic [7:0]  drv [4]  = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  bsio_xrsp_t  xbus_rsp;
  logic [7:0]  low_pin_out, low_pin_oe_n, high_pin_out, high_pin_oe_n;
  logic [3:0]  ctl_pin_out, ctl_pin_oe_n;
  logic [7:0]  an_pin_out, an_pin_oe_n;
  logic        fourth_capture_input;
  logic        analog_mode;
  logic [15:0] mem_drv;
  logic [15:0] ad_res;
  logic [3:0]  ctl_res;
  logic [7:0]  an_res;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  logic [7:0]  rnd       = 8'd67;
  logic [32:0] rq [$];
  logic [16:0] xq [$];
  logic [15:0] xaddr     = 16'h0;

  // pin levels: design driver first, then the far side
  assign ad_res = (~{high_pin_oe_n, low_pin_oe_n} & {high_pin_out, low_pin_out})
    | ({high_pin_oe_n, low_pin_oe_n} & (attached ? mem_drv : {drv[1], drv[0]}));
  assign ctl_res = (~ctl_pin_oe_n & ctl_pin_out) | (ctl_pin_oe_n & drv[2][3:0]);
  assign an_res = (~an_pin_oe_n & an_pin_out) | (an_pin_oe_n & drv[3]);

  always #2 mclk = ~mclk;

  bsio_top i_bsio_top (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_mode(cfg_mode),
    .xbus_req(xbus_req), .xbus_rsp(xbus_rsp),
    .low_pin_in(ad_res[7:0]), .low_pin_out(low_pin_out),
    .low_pin_oe_n(low_pin_oe_n), .high_pin_in(ad_res[15:8]),
    .high_pin_out(high_pin_out), .high_pin_oe_n(high_pin_oe_n),
    .ctl_pin_in(ctl_res), .ctl_pin_out(ctl_pin_out),
    .ctl_pin_oe_n(ctl_pin_oe_n), .an_pin_in(an_res),
    .an_pin_out(an_pin_out), .an_pin_oe_n(an_pin_oe_n),
    .fourth_capture_input(fourth_capture_input), .analog_mode(analog_mode)
  );

  bsio_mem_model i_bsio_mem_model (
    .mclk(mclk), .attached(attached), .ale(ctl_res[0]), .oe_n(ctl_res[1]),
    .wr_n(ctl_res[2]), .ad(ad_res), .drv(mem_drv)
  );

  function automatic logic [15:0] pins(input int k);
    case (k)
      0: return {low_pin_oe_n, low_pin_out};
      1: return {high_pin_oe_n, high_pin_out};
      2: return {4'h0, ctl_pin_oe_n, 4'h0, ctl_pin_out};
      default: return {an_pin_oe_n, an_pin_out};
    endcase
  endfunction

  task automatic roll(output logic [7:0] v);
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    v = rnd;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    rq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask

  task automatic xfer(input logic we, input logic [15:0] a,
                      input logic [15:0] d);
    xaddr = a;
    xq.push_back({~we, d});
    xbus_req <= {1'b1, we, a, d};
    do begin
      @(posedge mclk);
    end while (xbus_rsp.done !== 1'b1);
    xbus_req.valid <= 1'b0;
    @(posedge mclk);
  endtask

  // answer monitor and run limit
  always @(posedge mclk) begin
    logic [32:0] e;
    logic [16:0] x;
    cyc <= cyc + 1;
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e = rq.pop_front();
      check(prdata, e[31:0]);
      check(32'(pslverr), 32'(e[32]));
    end
    if (xbus_rsp.done === 1'b1) begin
      if (xq.size() == 0)
        check(32'h1, 32'h0);
      else begin
        x = xq.pop_front();
        if (x[16])
          check(32'(xbus_rsp.rdata), 32'(x[15:0]));
      end
    end
    if (attached && ctl_pin_out[0] === 1'b1 && ctl_pin_oe_n[0] === 1'b0)
      check({high_pin_oe_n, low_pin_oe_n, high_pin_out, low_pin_out},
            32'(xaddr));
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    logic [7:0]  r, p, m, msk, da, dd;
    logic [15:0] a;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(A_LOW_DIR, 32'hff, 1'b0);
    rd(A_HIGH_DIR, 32'hff, 1'b0);
    rd(A_CTL_DIR, 32'h0f, 1'b0);
    rd(A_AN_CFG, 32'h1, 1'b0);
    rd(A_STATUS, 32'h2, 1'b0);
    rd(8'h68, 32'h0, 1'b1);
    rd(8'h41, 32'h0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      da = A_LOW_DIR + 8'(8 * k);
      dd = da + 8'h04;
      msk = (k == 2) ? 8'h0f : 8'hff;
      roll(r);
      roll(p);
      roll(m);
      drv[k] <= p;
      wr(dd, 32'h0);
      wr(dd, 32'(r));
      settle();
      check(32'(pins(k) >> 8), 32'(msk));
      rd(dd, 32'(p & msk), 1'b0);
      wr(da, 32'(m));
      settle();
      check(32'(pins(k) & {8'hff, ~m & msk}),
            32'({m & msk, r & ~m & msk}));
      rd(da, 32'(m & msk), 1'b0);
      rd(dd, 32'(((r & ~m) | (p & m)) & msk), 1'b0);
    end
    check(32'(fourth_capture_input), 32'(ctl_res[3]));
    roll(p);
    drv[3] <= p;
    wr(A_AN_DAT, 32'h5a);
    wr(A_AN_DIR, 32'h0);
    settle();
    check(32'(an_pin_oe_n), 32'hff);
    check(32'(analog_mode), 32'h1);
    rd(A_AN_DAT, 32'h0, 1'b0);
    wr(A_AN_CFG, 32'h0);
    settle();
    check(32'(pins(3)), 32'h005a);
    check(32'(analog_mode), 32'h0);
    rd(A_AN_DAT, 32'h5a, 1'b0);
    // a core request outside bus modes gets no answer
    xbus_req <= {1'b1, 1'b0, 16'h0012, 16'h0000};
    repeat (10) @(posedge mclk);
    xbus_req.valid <= 1'b0;
    wr(A_HIGH_DIR, 32'h0);
    cfg_mode <= MODE_MICROPROC;
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    attached <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(A_HIGH_DIR, 32'hff, 1'b0);
    rd(A_STATUS, 32'h4, 1'b0);
    settle();
    check(32'(pins(2) & 16'h0707), 32'h0006);
    wr(A_LOW_DIR, 32'h0);
    wr(A_LOW_DAT, 32'h33);
    wr(A_CTL_DIR, 32'h07);
    wr(A_CTL_DAT, 32'h08);
    settle();
    check(32'(pins(2) & 16'h0f0f), 32'h000e);
    for (int i = 0; i < 4; i++) begin
      roll(r);
      roll(p);
      a = {r, p};
      roll(r);
      roll(m);
      xfer(1'b1, a, {r, m});
      xfer(1'b0, a, {r, m});
    end
    // read and write strobes idle high while released (ALE low), so no stray write
    drv[2] <= 8'h06;
    cfg_mode <= MODE_EXT_MC;
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(A_STATUS, 32'h5, 1'b0);
    xfer(1'b0, a, {r, m});
    repeat (5) @(posedge mclk);
    check(32'(rq.size() + xq.size()), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

// ===== hdl/bsio_port.sv
`default_nettype none
module bsio_port
  import bsio_pkg::*;
#(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // register state
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] latch,
  // bus override and analog hold-off
  input  wire logic [W-1:0] own,
  input  wire logic [W-1:0] ovr_out,
  input  wire logic [W-1:0] ovr_oe_n,
  input  wire logic [W-1:0] force_in,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q   <= '0;
      pin_sync <= '0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end

  // one bit of dir high releases the pin; owner overrides both
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= (own & ovr_out) | (~own & latch);
      pin_oe_n <= force_in | (own & ovr_oe_n) | (~own & dir);
    end
  end

endmodule
`default_nettype wire

// ===== hdl/bsio_top.sv
`default_nettype none
module bsio_top
  import bsio_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // operating mode strap
  input  wire logic [1:0]  cfg_mode,
  // core access to the multiplexed bus
  input  wire bsio_xreq_t  xbus_req,
  output bsio_xrsp_t       xbus_rsp,
  // low byte pins
  input  wire logic [7:0]  low_pin_in,
  output logic      [7:0]  low_pin_out,
  output logic      [7:0]  low_pin_oe_n,
  // high byte pins
  input  wire logic [7:0]  high_pin_in,
  output logic      [7:0]  high_pin_out,
  output logic      [7:0]  high_pin_oe_n,
  // bus control pins
  input  wire logic [3:0]  ctl_pin_in,
  output logic      [3:0]  ctl_pin_out,
  output logic      [3:0]  ctl_pin_oe_n,
  // analog-shared pins
  input  wire logic [7:0]  an_pin_in,
  output logic      [7:0]  an_pin_out,
  output logic      [7:0]  an_pin_oe_n,
  // peripheral side
  output logic             fourth_capture_input,
  output logic             analog_mode
);

  logic [7:0]  low_dir_q;
  logic [7:0]  low_dat_q;
  logic [7:0]  high_dir_q;
  logic [7:0]  high_dat_q;
  logic [3:0]  ctl_dir_q;
  logic [3:0]  ctl_dat_q;
  logic [7:0]  an_dir_q;
  logic [7:0]  an_dat_q;
  logic [1:0]  mode_q;
  logic        mode_ok_q;
  logic        bus_own_q;
  logic [7:0]  low_sync;
  logic [7:0]  high_sync;
  logic [3:0]  ctl_sync;
  logic [7:0]  an_sync;
  logic [15:0] ad_out;
  logic [15:0] ad_oe_n;
  logic        seq_ale;
  logic        seq_oe_n;
  logic        seq_wr_n;
  logic        acc_first;
  logic        wr_go;
  logic        hit;
  logic [31:0] rd_d;

  // strap is caught once, on the first edge after reset release
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_q    <= MODE_RST;
      mode_ok_q <= 1'b0;
    end else if (!mode_ok_q) begin
      mode_q    <= cfg_mode;
      mode_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) bus_own_q <= 1'b0;
    else bus_own_q <= mode_ok_q && is_bus_mode(mode_q);
  end

  // apb: one wait state, answer on the second access cycle
  assign acc_first = psel && penable && !pready;
  assign wr_go     = psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      A_LOW_DIR, A_LOW_DAT, A_HIGH_DIR, A_HIGH_DAT, A_CTL_DIR,
      A_CTL_DAT, A_AN_DIR, A_AN_DAT, A_AN_CFG, A_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first && !hit;
      prdata  <= acc_first ? rd_d : 32'h0000_0000;
    end
  end

  // data reads show pins, not latches; the analog data register reads zero in analog mode
  always_comb begin
    rd_d = '0;
    unique case (paddr)
      A_LOW_DIR:  rd_d[7:0] = low_dir_q;
      A_LOW_DAT:  rd_d[7:0] = low_sync;
      A_HIGH_DIR: rd_d[7:0] = high_dir_q;
      A_HIGH_DAT: rd_d[7:0] = high_sync;
      A_CTL_DIR:  rd_d[3:0] = ctl_dir_q;
      A_CTL_DAT:  rd_d[3:0] = ctl_sync;
      A_AN_DIR:   rd_d[7:0] = an_dir_q;
      A_AN_DAT:   rd_d[7:0] = analog_mode ? 8'h00 : an_sync;
      A_AN_CFG:   rd_d[0]   = analog_mode;
      A_STATUS:   rd_d[ST_BUS_BIT:0] = {bus_own_q, mode_q};
      default:    rd_d = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_dir_q  <= DIR8_RST;
      high_dir_q <= DIR8_RST;
      ctl_dir_q  <= DIR4_RST;
      an_dir_q   <= DIR8_RST;
    end else if (wr_go) begin
      unique case (paddr)
        A_LOW_DIR:  low_dir_q  <= pwdata[7:0];
        A_HIGH_DIR: high_dir_q <= pwdata[7:0];
        A_CTL_DIR:  ctl_dir_q  <= pwdata[3:0];
        A_AN_DIR:   an_dir_q   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // latch writes never touch the pins directly
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_dat_q  <= DAT8_RST;
      high_dat_q <= DAT8_RST;
      ctl_dat_q  <= DAT4_RST;
      an_dat_q   <= DAT8_RST;
    end else if (wr_go) begin
      unique case (paddr)
        A_LOW_DAT:  low_dat_q  <= pwdata[7:0];
        A_HIGH_DAT: high_dat_q <= pwdata[7:0];
        A_CTL_DAT:  ctl_dat_q  <= pwdata[3:0];
        A_AN_DAT:   an_dat_q   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) analog_mode <= ANL_RST;
    else if (wr_go && paddr == A_AN_CFG) analog_mode <= pwdata[0];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) fourth_capture_input <= 1'b0;
    else fourth_capture_input <= ctl_sync[CTL_CAP_BIT];
  end

  bsio_xbus u_xbus (
    .mclk    (mclk),
    .reset   (reset),
    .en      (bus_own_q),
    .req     (xbus_req),
    .rsp     (xbus_rsp),
    .ad_in   ({high_sync, low_sync}),
    .ad_out  (ad_out),
    .ad_oe_n (ad_oe_n),
    .ale     (seq_ale),
    .oe_n    (seq_oe_n),
    .wr_n    (seq_wr_n)
  );

  // bus ownership overrides direction and latch per pin
  bsio_port #(.W(8)) u_low (
    .mclk     (mclk),
    .reset    (reset),
    .dir      (low_dir_q),
    .latch    (low_dat_q),
    .own      ({8{bus_own_q}}),
    .ovr_out  (ad_out[7:0]),
    .ovr_oe_n (ad_oe_n[7:0]),
    .force_in (8'h00),
    .pin_in   (low_pin_in),
    .pin_out  (low_pin_out),
    .pin_oe_n (low_pin_oe_n),
    .pin_sync (low_sync)
  );

  bsio_port #(.W(8)) u_high (
    .mclk     (mclk),
    .reset    (reset),
    .dir      (high_dir_q),
    .latch    (high_dat_q),
    .own      ({8{bus_own_q}}),
    .ovr_out  (ad_out[15:8]),
    .ovr_oe_n (ad_oe_n[15:8]),
    .force_in (8'h00),
    .pin_in   (high_pin_in),
    .pin_out  (high_pin_out),
    .pin_oe_n (high_pin_oe_n),
    .pin_sync (high_sync)
  );

  // bit 3 is never owned by the bus
  bsio_port #(.W(4)) u_ctl (
    .mclk     (mclk),
    .reset    (reset),
    .dir      (ctl_dir_q),
    .latch    (ctl_dat_q),
    .own      ({1'b0, {3{bus_own_q}}}),
    .ovr_out  ({1'b0, seq_wr_n, seq_oe_n, seq_ale}),
    .ovr_oe_n (4'h8),
    .force_in (4'h0),
    .pin_in   (ctl_pin_in),
    .pin_out  (ctl_pin_out),
    .pin_oe_n (ctl_pin_oe_n),
    .pin_sync (ctl_sync)
  );

  // analog mode keeps all eight drivers off for the converter
  bsio_port #(.W(8)) u_an (
    .mclk     (mclk),
    .reset    (reset),
    .dir      (an_dir_q),
    .latch    (an_dat_q),
    .own      (8'h00),
    .ovr_out  (8'h00),
    .ovr_oe_n (8'hff),
    .force_in ({8{analog_mode}}),
    .pin_in   (an_pin_in),
    .pin_out  (an_pin_out),
    .pin_oe_n (an_pin_oe_n),
    .pin_sync (an_sync)
  );

  dir_drive_a: assert property (
    @(posedge mclk) disable iff (reset)
      !analog_mode && !$past(analog_mode) |-> an_pin_oe_n == $past(an_dir_q))
    else $error("analog-shared pin enable does not follow direction");

  latch_only_a: assert property (
    @(posedge mclk) disable iff (reset)
      wr_go && paddr == A_AN_DAT |=> an_dat_q == $past(pwdata[7:0])
        ##1 an_pin_out == $past(an_dat_q))
    else $error("latch write did not reach pin output");

  read_pins_a: assert property (
    @(posedge mclk) disable iff (reset)
      acc_first && !pwrite && paddr == A_LOW_DAT
        |=> pready && prdata[7:0] == $past(low_sync))
    else $error("port read did not return pin levels");

  ctl_upper_a: assert property (
    @(posedge mclk) disable iff (reset)
      acc_first && (paddr == A_CTL_DAT || paddr == A_CTL_DIR)
        |=> prdata[31:4] == 28'h0000000)
    else $error("control port upper bits not zero");

  high_bus_a: assert property (
    @(posedge mclk) disable iff (reset)
      bus_own_q && $past(bus_own_q) |-> high_pin_out == $past(ad_out[15:8])
        && high_pin_oe_n == $past(ad_oe_n[15:8]))
    else $error("high port not carrying upper bus byte");

  low_bus_a: assert property (
    @(posedge mclk) disable iff (reset)
      bus_own_q && $past(bus_own_q) |-> low_pin_out == $past(ad_out[7:0])
        && low_pin_oe_n == $past(ad_oe_n[7:0]))
    else $error("low port not carrying lower bus byte");

  ctl_map_a: assert property (
    @(posedge mclk) disable iff (reset)
      bus_own_q && $past(bus_own_q) |-> ctl_pin_oe_n[2:0] == 3'h0
        && ctl_pin_out[2:0] == $past({seq_wr_n, seq_oe_n, seq_ale}))
    else $error("control strobes on wrong pins");

  cap_free_a: assert property (
    @(posedge mclk) disable iff (reset)
      ##1 ctl_pin_oe_n[3] == $past(ctl_dir_q[3])
        && ctl_pin_out[3] == $past(ctl_dat_q[3]))
    else $error("control bit 3 taken from software");

  gpio_ctl_a: assert property (
    @(posedge mclk) disable iff (reset)
      !bus_own_q && !$past(bus_own_q)
        |-> ctl_pin_out[2:0] == $past(ctl_dat_q[2:0]))
    else $error("control pins not plain I/O outside bus mode");

  mode_own_a: assert property (
    @(posedge mclk) disable iff (reset)
      mode_ok_q |=> bus_own_q == is_bus_mode($past(mode_q)))
    else $error("bus ownership does not follow mode");

  reset_dir_a: assert property (
    @(posedge mclk) disable iff (reset)
      $past(reset) |-> low_dir_q == DIR8_RST && high_dir_q == DIR8_RST
        && ctl_dir_q == DIR4_RST && an_dir_q == DIR8_RST && analog_mode)
    else $error("directions or analog mode wrong after reset");

endmodule
`default_nettype wire

// ===== hdl/bsio_xbus.sv
`default_nettype none
module bsio_xbus
  import bsio_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // control
  input  wire logic        en,
  input  wire bsio_xreq_t  req,
  output bsio_xrsp_t       rsp,
  // address/data lines
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] ad_oe_n,
  // strobes
  output logic             ale,
  output logic             oe_n,
  output logic             wr_n
);

  bsio_seq_t  st_q;
  logic [2:0] cnt_q;
  logic       we_q;
  logic [15:0] wd_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q  <= SQ_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        SQ_IDLE: if (en && req.valid) begin
          st_q  <= SQ_ADDR;
          cnt_q <= '0;
        end
        SQ_ADDR: if (cnt_q == SEQ_ALE_CYC - 3'd1) begin
          st_q  <= SQ_DATA;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 3'd1;
        end
        SQ_DATA: if (cnt_q == SEQ_DATA_CYC - 3'd1) begin
          st_q <= SQ_DONE;
        end else begin
          cnt_q <= cnt_q + 3'd1;
        end
        SQ_DONE: st_q <= SQ_IDLE;
      endcase
    end
  end

  // strobe and line drive for each phase
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ad_out  <= '0;
      ad_oe_n <= '1;
      ale     <= 1'b0;
      oe_n    <= 1'b1;
      wr_n    <= 1'b1;
      we_q    <= 1'b0;
      wd_q    <= '0;
      rsp     <= '0;
    end else begin
      rsp.done <= 1'b0;
      unique case (st_q)
        SQ_IDLE: if (en && req.valid) begin
          we_q    <= req.we;
          wd_q    <= req.wdata;
          ad_out  <= req.addr;
          ad_oe_n <= '0;
          ale     <= 1'b1;
        end
        SQ_ADDR: if (cnt_q == SEQ_ALE_CYC - 3'd1) begin
          ale <= 1'b0;
          if (we_q) begin
            ad_out <= wd_q;
            wr_n   <= 1'b0;
          end else begin
            ad_oe_n <= '1;
            oe_n    <= 1'b0;
          end
        end
        SQ_DATA: if (cnt_q == SEQ_DATA_CYC - 3'd1) begin
          if (!we_q) rsp.rdata <= ad_in;
          oe_n     <= 1'b1;
          wr_n     <= 1'b1;
          ad_oe_n  <= '1;
          rsp.done <= 1'b1;
        end
        SQ_DONE: ;
      endcase
    end
  end

  sequence s_addr_phase;
    $rose(ale);
  endsequence

  sequence s_strobe_phase;
    !ale && (oe_n != wr_n);
  endsequence

  sequence s_release;
    oe_n && wr_n && ad_oe_n == 16'hffff && rsp.done;
  endsequence

  strobe_order_a: assert property (
    @(posedge mclk) disable iff (reset)
      s_addr_phase |=> s_strobe_phase ##4 s_release)
    else $error("bus strobe sequence out of order");

endmodule
`default_nettype wire

// ===== inc/bsio_pkg.sv
`default_nettype none
package bsio_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOW_DIR  = 8'h10;
  localparam logic [7:0] IDX_LOW_DAT  = 8'h11;
  localparam logic [7:0] IDX_HIGH_DIR = 8'h12;
  localparam logic [7:0] IDX_HIGH_DAT = 8'h13;
  localparam logic [7:0] IDX_CTL_DIR  = 8'h14;
  localparam logic [7:0] IDX_CTL_DAT  = 8'h15;
  localparam logic [7:0] IDX_AN_DIR   = 8'h16;
  localparam logic [7:0] IDX_AN_DAT   = 8'h17;
  localparam logic [7:0] IDX_AN_CFG   = 8'h18;
  localparam logic [7:0] IDX_STATUS   = 8'h19;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  localparam logic [7:0] A_LOW_DIR  = reg_addr(IDX_LOW_DIR);
  localparam logic [7:0] A_LOW_DAT  = reg_addr(IDX_LOW_DAT);
  localparam logic [7:0] A_HIGH_DIR = reg_addr(IDX_HIGH_DIR);
  localparam logic [7:0] A_HIGH_DAT = reg_addr(IDX_HIGH_DAT);
  localparam logic [7:0] A_CTL_DIR  = reg_addr(IDX_CTL_DIR);
  localparam logic [7:0] A_CTL_DAT  = reg_addr(IDX_CTL_DAT);
  localparam logic [7:0] A_AN_DIR   = reg_addr(IDX_AN_DIR);
  localparam logic [7:0] A_AN_DAT   = reg_addr(IDX_AN_DAT);
  localparam logic [7:0] A_AN_CFG   = reg_addr(IDX_AN_CFG);
  localparam logic [7:0] A_STATUS   = reg_addr(IDX_STATUS);

  // reset values
  localparam logic [7:0] DIR8_RST  = 8'hff;
  localparam logic [3:0] DIR4_RST  = 4'hf;
  localparam logic [7:0] DAT8_RST  = 8'h00;
  localparam logic [3:0] DAT4_RST  = 4'h0;
  localparam logic       ANL_RST   = 1'b1;
  localparam logic [1:0] MODE_RST  = 2'h2;

  // field positions
  localparam int unsigned CTL_ALE_BIT = 0;
  localparam int unsigned CTL_OE_BIT  = 1;
  localparam int unsigned CTL_WR_BIT  = 2;
  localparam int unsigned CTL_CAP_BIT = 3;
  localparam int unsigned ST_BUS_BIT  = 2;

  // operating modes; the two with mode[1] low use the system bus
  localparam logic [1:0] MODE_MICROPROC = 2'h0;
  localparam logic [1:0] MODE_EXT_MC    = 2'h1;

  function automatic logic is_bus_mode(input logic [1:0] m);
    return (m == MODE_MICROPROC) || (m == MODE_EXT_MC);
  endfunction

  // bus sequencer phase lengths in mclk cycles; the data phase
  // covers pin register, far side and the two-stage input sync
  localparam logic [2:0] SEQ_ALE_CYC  = 3'd1;
  localparam logic [2:0] SEQ_DATA_CYC = 3'd4;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_ADDR = 2'b01,
    SQ_DATA = 2'b11,
    SQ_DONE = 2'b10
  } bsio_seq_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bsio_xreq_t;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } bsio_xrsp_t;

endpackage
`default_nettype wire
